// file: rtl/mcj_pkg.sv
// Constants and types for the spare monitoring channel and its jitter meter.
// Assumes one clock (mclk, 20 MHz) and a synchronous active-high reset.
//
// Summary of operation
// [R01] Spare channel works as an ordinary line channel or as a monitor.
// [R02] Six-bit source select picks any rx/tx of sixteen channels; zero is off.
// [R03] Monitoring forces external impedance match, ignoring the termination setting.
// [R04] Software programs spare receiver like the monitored path, line settings excepted.
// [R05] Monitored signal is processed normally; monitored path itself is untouched.
// [R06] Monitored signal goes through recovery onto spare receive clock and data.
// [R07] Spare loss-of-signal detector keeps watching the monitored signal.
// [R08] In monitor mode remote loopback drives the monitored signal onto spare transmit.
// [R09] Jitter meter runs only while the spare jitter attenuator is enabled.
// [R10] Control bit 0 selects the measured jitter bandwidth.
// [R11] Peaks reported as high/low byte pair equal to jitter UIpp times 16.
// [R12] Control bit 1 picks one-second automatic period or manual period.
// [R13] One-second timer counts master clock cycles.
// [R14] Each expiry sets overflow flag bit 0; interrupt raised unless mask bit 0.
// [R15] Overflow flag clears only when software writes one to it.
// [R16] On expiry peaks are copied to report registers and buffers cleared.
// [R17] In manual mode a rising stop bit 2 copies peaks and clears buffers.
// [R18] Software reads peaks before the next update overwrites them.
// [R19] Peak buffers keep the larger of stored value and new sample.
// [R20] Reset clears buffers, reported peaks and the one-second timer.
package mcj_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_MONITOR_SELECT  = 4'h0;
  localparam logic [3:0] ADDR_JITTER_CONTROL  = 4'h1;
  localparam logic [3:0] ADDR_TIMER_STATUS    = 4'h2;
  localparam logic [3:0] ADDR_POS_PEAK_HIGH   = 4'h3;
  localparam logic [3:0] ADDR_POS_PEAK_LOW    = 4'h4;
  localparam logic [3:0] ADDR_NEG_PEAK_HIGH   = 4'h5;
  localparam logic [3:0] ADDR_NEG_PEAK_LOW    = 4'h6;
  localparam logic [3:0] ADDR_GLOBAL_CONFIG   = 4'h7;
  localparam logic [3:0] ADDR_CHANNEL_CONTROL = 4'h8;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_BANDWIDTH    = 0;
  localparam int BIT_PERIOD_MODE  = 1;
  localparam int BIT_MANUAL_STOP  = 2;
  localparam int BIT_OVERFLOW     = 0;
  localparam int BIT_OVF_MASK     = 0;
  localparam int BIT_RJA_ENABLE   = 0;
  localparam int BIT_REMOTE_LOOP  = 1;
  localparam int SEL_MSB          = 5;
  localparam int TERM_MSB         = 2;
  localparam int TERM_LSB         = 4;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_MONITOR_SELECT = 8'h00;
  localparam logic [7:0] RST_JITTER_CONTROL = 8'h00;
  localparam logic [7:0] RST_GLOBAL_CONFIG  = 8'h00;
  localparam logic [7:0] RST_CHANNEL_CTRL   = 8'h00;
  localparam logic [7:0] RST_UNMAPPED       = 8'h00;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLOCK_HZ      = 20_000_000;
  localparam int PERIOD_MS     = 1000;
  localparam int PERIOD_CYCLES = CLOCK_HZ / 1000 * PERIOD_MS;

  // Peak width: sixteen bits, the high/low register pair
  localparam int PEAK_W = 16;

  typedef enum logic [1:0] {
    MCJ_IDLE,
    MCJ_MEASURE
  } mcj_state_t;

endpackage

// file: rtl/mcj_peak_if.sv
// Carrier between jitter meter top and its peak store.
// Assumes both ends run on the same mclk.
`timescale 1ns/10ps
interface mcj_peak_if;
  import mcj_pkg::*;
  logic              sample_valid;
  logic [PEAK_W-1:0] pos_sample;
  logic [PEAK_W-1:0] neg_sample;
  logic              transfer;
  logic              clear;
  logic [PEAK_W-1:0] pos_report;
  logic [PEAK_W-1:0] neg_report;

  modport ctrl  (output sample_valid, output pos_sample, output neg_sample,
                 output transfer, output clear, input pos_report, input neg_report);
  modport store (input sample_valid, input pos_sample, input neg_sample,
                 input transfer, input clear, output pos_report, output neg_report);
endinterface

// file: rtl/mcj_peak_store.sv
// Peak buffers and reported peak registers of the jitter meter.
// Assumes samples and transfer pulses are synchronous to mclk.
`timescale 1ns/10ps
module mcj_peak_store (
  input  wire logic   mclk,
  input  wire logic   rst,
  mcj_peak_if.store   pk
);
  import mcj_pkg::*;

  typedef struct packed {
    logic [PEAK_W-1:0] pos_buf;
    logic [PEAK_W-1:0] neg_buf;
    logic [PEAK_W-1:0] pos_rep;
    logic [PEAK_W-1:0] neg_rep;
  } mcj_store_t;

  mcj_store_t st;
  mcj_store_t next_st;

  // ------------------------------------------------------------
  // Accumulate and transfer
  // ------------------------------------------------------------
  // The sample in the transfer cycle joins the outgoing round so none is lost
  always_comb begin
    logic [PEAK_W-1:0] pmax;
    logic [PEAK_W-1:0] nmax;
    pmax = st.pos_buf;
    nmax = st.neg_buf;
    next_st = st;
    if (pk.sample_valid) begin
      if (pk.pos_sample > pmax) pmax = pk.pos_sample; // R19
      if (pk.neg_sample > nmax) nmax = pk.neg_sample; // R19
    end
    next_st.pos_buf = pmax;
    next_st.neg_buf = nmax;
    if (pk.transfer) begin
      next_st.pos_rep = pmax; // R16 R17
      next_st.neg_rep = nmax;
      next_st.pos_buf = '0;   // R16 R17
      next_st.neg_buf = '0;
    end else if (pk.clear) begin
      next_st.pos_buf = '0;
      next_st.neg_buf = '0;
    end
  end

  // Reset empties everything
  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '0; // R20
    end else begin
      st <= next_st;
    end
  end

  assign pk.pos_report = st.pos_rep;
  assign pk.neg_report = st.neg_rep;
endmodule

// file: rtl/mcj_monitor.sv
// Spare channel monitor routing and jitter meter with its register port.
// Assumes a plain register port on mclk and line paths sampled on mclk.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/10ps
module mcj_monitor #(
  parameter int NUM_CH        = 16,
  parameter int PERIOD_COUNT  = mcj_pkg::PERIOD_CYCLES
) (
  input  wire logic                       mclk,
  input  wire logic                       rst,
  // Register port
  input  wire logic [3:0]                 reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_write,
  input  wire logic                       reg_read,
  output logic [7:0]                      reg_rdata,
  // Line paths of the regular channels (index 0 picked by code 1 on rx, code 17 on tx)
  input  wire logic [NUM_CH-1:0]          rx_line_data,
  input  wire logic [NUM_CH-1:0]          tx_line_data,
  // Spare channel own receive line
  input  wire logic                       spare_line_data,
  // Recovered clock and data from spare recovery circuit
  input  wire logic                       spare_cdr_clock,
  input  wire logic                       spare_cdr_data,
  input  wire logic                       spare_los_detect,
  // Jitter samples from demodulator
  input  wire logic                       jitter_valid,
  input  wire logic [mcj_pkg::PEAK_W-1:0] jitter_pos,
  input  wire logic [mcj_pkg::PEAK_W-1:0] jitter_neg,
  // To the spare channel analog and recovery
  output logic                            spare_cdr_input,
  output logic                            spare_external_match,
  output logic [2:0]                      spare_termination,
  output logic                            spare_monitor_active,
  output logic                            spare_receive_clock_out,
  output logic                            spare_receive_data_out,
  output logic                            spare_los,
  output logic                            spare_transmit_data,
  output logic                            spare_transmit_loop,
  output logic                            jitter_bandwidth_select,
  output logic                            jitter_meter_running,
  output logic                            int_n
);
  import mcj_pkg::*;

  mcj_peak_if pk ();

  typedef struct packed {
    logic [7:0]  monitor_select;
    logic [7:0]  jitter_control;
    logic [7:0]  global_configuration;
    logic [7:0]  channel_control;
    logic        timer_overflow_flag;
    logic [31:0] sec_count;
    logic        stop_prev;
    logic [7:0]  rdata;
    logic        cdr_input;
    logic        ext_match;
    logic [2:0]  term;
    logic        mon_active;
    logic        rclk;
    logic        rdat;
    logic        los;
    logic        tx_data;
    logic        tx_loop;
    logic        bw;
    logic        run;
    logic        irq_n;
    mcj_state_t  state;
  } mcj_regs_t;

  mcj_regs_t r;
  mcj_regs_t next_r;

  // ------------------------------------------------------------
  // Source decode
  // ------------------------------------------------------------
  // Codes 1..N pick a receiver, N+1..2N a transmitter; others read as off
  function automatic logic pick_source(input logic [5:0] sel,
                                       input logic [NUM_CH-1:0] rx,
                                       input logic [NUM_CH-1:0] tx);
    int idx;
    logic v;
    idx = int'(sel);
    v = 1'b0;
    if (idx >= 1 && idx <= NUM_CH) v = rx[idx-1];
    else if (idx > NUM_CH && idx <= 2 * NUM_CH) v = tx[idx-NUM_CH-1];
    return v;
  endfunction

  function automatic logic source_valid(input logic [5:0] sel);
    return (int'(sel) >= 1) && (int'(sel) <= 2 * NUM_CH);
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic monitor_on;
  logic auto_mode;
  logic sec_expire;
  logic manual_stop_rise;
  logic transfer;

  always_comb begin
    next_r = r;
    monitor_on = source_valid(r.monitor_select[SEL_MSB:0]); // R01 R02
    auto_mode = r.jitter_control[BIT_PERIOD_MODE];          // R12
    sec_expire = 1'b0;
    manual_stop_rise = 1'b0;

    // Meter runs only with the spare jitter attenuator on
    next_r.run = r.channel_control[BIT_RJA_ENABLE]; // R09
    next_r.state = r.channel_control[BIT_RJA_ENABLE] ? MCJ_MEASURE : MCJ_IDLE;

    // One-second timer from mclk, held at zero when idle or manual
    if (r.state == MCJ_MEASURE && auto_mode) begin
      if (r.sec_count == 32'(PERIOD_COUNT - 1)) begin // R13
        sec_expire = 1'b1;
        next_r.sec_count = '0;
      end else begin
        next_r.sec_count = r.sec_count + 32'h1;
      end
    end else begin
      next_r.sec_count = '0;
    end

    // Manual stop edge detector on the software bit
    next_r.stop_prev = r.jitter_control[BIT_MANUAL_STOP];
    manual_stop_rise = r.state == MCJ_MEASURE && !auto_mode &&
                       r.jitter_control[BIT_MANUAL_STOP] && !r.stop_prev; // R17
    transfer = sec_expire || manual_stop_rise; // R16

    // Register writes
    if (reg_write) begin
      unique case (reg_addr)
        ADDR_MONITOR_SELECT:  next_r.monitor_select = {2'b00, reg_wdata[SEL_MSB:0]};
        ADDR_JITTER_CONTROL:  next_r.jitter_control = {5'b00000, reg_wdata[2:0]};
        ADDR_GLOBAL_CONFIG:   next_r.global_configuration = {7'h00, reg_wdata[0]};
        ADDR_CHANNEL_CONTROL: next_r.channel_control = {3'b000, reg_wdata[4:0]};
        ADDR_TIMER_STATUS:
          if (reg_wdata[BIT_OVERFLOW]) next_r.timer_overflow_flag = 1'b0; // R15
        default: ;
      endcase
    end
    // Set beats a simultaneous clear
    if (sec_expire) next_r.timer_overflow_flag = 1'b1; // R14

    // Read data, one cycle after the strobe
    next_r.rdata = RST_UNMAPPED;
    if (reg_read) begin
      unique case (reg_addr)
        ADDR_MONITOR_SELECT:  next_r.rdata = r.monitor_select;
        ADDR_JITTER_CONTROL:  next_r.rdata = r.jitter_control;
        ADDR_TIMER_STATUS:    next_r.rdata = {7'h00, r.timer_overflow_flag};
        ADDR_POS_PEAK_HIGH:   next_r.rdata = pk.pos_report[15:8]; // R11
        ADDR_POS_PEAK_LOW:    next_r.rdata = pk.pos_report[7:0];
        ADDR_NEG_PEAK_HIGH:   next_r.rdata = pk.neg_report[15:8]; // R11
        ADDR_NEG_PEAK_LOW:    next_r.rdata = pk.neg_report[7:0];
        ADDR_GLOBAL_CONFIG:   next_r.rdata = r.global_configuration;
        ADDR_CHANNEL_CONTROL: next_r.rdata = r.channel_control;
        default:              next_r.rdata = RST_UNMAPPED;
      endcase
    end

    // Spare channel input: monitored path or own line, monitored path untouched
    next_r.mon_active = monitor_on;
    next_r.cdr_input = monitor_on ?
      pick_source(r.monitor_select[SEL_MSB:0], rx_line_data, tx_line_data) // R05
      : spare_line_data;
    // Monitoring forces external match and parks termination
    next_r.ext_match = monitor_on; // R03
    next_r.term = monitor_on ? 3'b000 : r.channel_control[TERM_LSB:TERM_MSB]; // R03
    // Recovered clock and data straight out
    next_r.rclk = spare_cdr_clock; // R06
    next_r.rdat = spare_cdr_data;  // R06
    next_r.los = spare_los_detect; // R07
    // Remote loopback sends the spare channel input (monitored path or own line) out on the spare transmit pair
    next_r.tx_loop = r.channel_control[BIT_REMOTE_LOOP];
    next_r.tx_data = r.channel_control[BIT_REMOTE_LOOP] ? r.cdr_input : 1'b0; // R08
    next_r.bw = r.jitter_control[BIT_BANDWIDTH]; // R10
    // Interrupt follows the sticky flag unless masked
    next_r.irq_n = !(next_r.timer_overflow_flag &&
                     !r.global_configuration[BIT_OVF_MASK]); // R14
  end

  // Peak store handshake
  assign pk.sample_valid = jitter_valid && r.state == MCJ_MEASURE; // R09
  assign pk.pos_sample   = jitter_pos;
  assign pk.neg_sample   = jitter_neg;
  assign pk.transfer     = transfer;
  assign pk.clear        = r.state == MCJ_IDLE;

  mcj_peak_store u_store (
    .mclk (mclk),
    .rst  (rst),
    .pk   (pk)
  );

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      r <= '0; // R20
      r.monitor_select <= RST_MONITOR_SELECT;
      r.jitter_control <= RST_JITTER_CONTROL;
      r.global_configuration <= RST_GLOBAL_CONFIG;
      r.channel_control <= RST_CHANNEL_CTRL;
      r.irq_n <= 1'b1;
      r.state <= MCJ_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flops
  assign reg_rdata               = r.rdata;
  assign spare_cdr_input         = r.cdr_input;
  assign spare_external_match    = r.ext_match;
  assign spare_termination       = r.term;
  assign spare_monitor_active    = r.mon_active;
  assign spare_receive_clock_out = r.rclk;
  assign spare_receive_data_out  = r.rdat;
  assign spare_los               = r.los;
  assign spare_transmit_data     = r.tx_data;
  assign spare_transmit_loop     = r.tx_loop;
  assign jitter_bandwidth_select = r.bw;
  assign jitter_meter_running    = r.run;
  assign int_n                   = r.irq_n;
endmodule

// file: test/mcj_monitor_monitor.sv
// Concurrent checks on the ports of the spare monitor and jitter meter.
// Assumes it is bound to mcj_monitor; a few control bits are shadowed from writes.
`timescale 1ns/10ps
module mcj_monitor_chk
  import mcj_pkg::*;
#(
  parameter int NUM_CH       = 16,
  parameter int PERIOD_COUNT = 100
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       spare_cdr_data,
  input wire logic       spare_los_detect,
  input wire logic       spare_cdr_input,
  input wire logic       spare_external_match,
  input wire logic [2:0] spare_termination,
  input wire logic       spare_monitor_active,
  input wire logic       spare_receive_data_out,
  input wire logic       spare_los,
  input wire logic       spare_transmit_data,
  input wire logic       spare_transmit_loop,
  input wire logic       jitter_bandwidth_select,
  input wire logic       jitter_meter_running,
  input wire logic       int_n
);
  logic bw_q;
  logic rja_q;
  logic mask_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // Shadow control bits
  // ------------------------------------------------------------
  // Only written bits are tracked; reads never change them
  always_ff @(posedge mclk) begin
    if (rst) begin
      bw_q   <= 1'b0;
      rja_q  <= 1'b0;
      mask_q <= 1'b0;
    end else if (reg_write) begin
      if (reg_addr == ADDR_JITTER_CONTROL) bw_q <= reg_wdata[BIT_BANDWIDTH];
      if (reg_addr == ADDR_CHANNEL_CONTROL) rja_q <= reg_wdata[BIT_RJA_ENABLE];
      if (reg_addr == ADDR_GLOBAL_CONFIG) mask_q <= reg_wdata[BIT_OVF_MASK];
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_select_on: assert property (
    reg_write && reg_addr == ADDR_MONITOR_SELECT && reg_wdata[5:0] inside {[1:32]}
    |-> ##[1:2] spare_monitor_active) else $error("monitor not active after select");
  a_select_off: assert property (
    reg_write && reg_addr == ADDR_MONITOR_SELECT && reg_wdata[5:0] == 6'h00
    |-> ##[1:2] !spare_monitor_active) else $error("monitor still active after off");
  a_match_forced: assert property (
    spare_monitor_active |-> spare_external_match && spare_termination == 3'h0)
    else $error("termination not overridden while monitoring");
  a_recover_path: assert property (
    !$past(rst) |-> spare_receive_data_out == $past(spare_cdr_data))
    else $error("recovered data not passed on");
  a_los_follow: assert property (
    !$past(rst) |-> spare_los == $past(spare_los_detect)) else $error("los not followed");
  a_loop_drive: assert property (
    spare_transmit_loop && $past(spare_transmit_loop)
    |-> spare_transmit_data == $past(spare_cdr_input)) else $error("loop data wrong");
  a_bw_follow: assert property (
    bw_q == $past(bw_q) && bw_q == $past(bw_q, 2) |-> jitter_bandwidth_select == bw_q)
    else $error("bandwidth select wrong");
  a_meter_gate: assert property (
    rja_q == $past(rja_q) && rja_q == $past(rja_q, 2) |-> jitter_meter_running == rja_q)
    else $error("meter run state wrong");
  a_int_masked: assert property (
    mask_q && $past(mask_q) && $past(mask_q, 2) |-> int_n) else $error("masked int raised");
  a_int_cause: assert property (
    $fell(int_n) |-> !$past(mask_q)) else $error("int raised while masked");

  // Main scenarios reached
  c_loop: cover property (spare_monitor_active && spare_transmit_loop);
  c_int: cover property ($fell(int_n));
  c_meter: cover property (jitter_meter_running && jitter_bandwidth_select);
endmodule

// file: test/mcj_far_end.sv
// Far-end model: regular line paths, spare recovery outputs, jitter samples.
// Assumes mclk from the bench; samples are issued through send().
`timescale 1ns/10ps
module mcj_far_end #(
  parameter int NUM_CH = 16
) (
  input  wire logic                  mclk,
  output logic [NUM_CH-1:0]          rx_line_data,
  output logic [NUM_CH-1:0]          tx_line_data,
  output logic                       spare_line_data,
  output logic                       spare_cdr_clock,
  output logic                       spare_cdr_data,
  output logic                       spare_los_detect,
  output logic                       jitter_valid,
  output logic [mcj_pkg::PEAK_W-1:0] jitter_pos,
  output logic [mcj_pkg::PEAK_W-1:0] jitter_neg
);
  import mcj_pkg::*;

  initial begin
    jitter_valid    = 1'b0;
    jitter_pos      = '0;
    jitter_neg      = '0;
  end

  // Paths change every cycle and never see the spare channel
  always @(posedge mclk) begin
    rx_line_data     <= NUM_CH'($urandom);
    tx_line_data     <= NUM_CH'($urandom);
    spare_line_data  <= 1'($urandom);
    spare_cdr_data   <= 1'($urandom);
    spare_los_detect <= 1'($urandom);
    spare_cdr_clock  <= 1'($urandom);
  end

  // One sample pulse; magnitudes are UIpp times 16, inverted once released
  task automatic send(input logic [PEAK_W-1:0] p, input logic [PEAK_W-1:0] n);
    @(posedge mclk);
    jitter_valid <= 1'b1;
    jitter_pos   <= p;
    jitter_neg   <= n;
    @(posedge mclk);
    jitter_valid <= 1'b0;
    jitter_pos   <= ~p;
    jitter_neg   <= ~n;
  endtask
endmodule

// file: test/testbench.sv
// Self-checking bench for the spare monitor and jitter meter.
// Assumes the far-end model, the bound checker and a 20 MHz mclk.
`timescale 1ns/10ps
module testbench;
  import mcj_pkg::*;
  localparam int P = 100;
  logic        mclk      = 1'b0;
  logic        rst       = 1'b1;
  logic [3:0]  reg_addr  = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read  = 1'b0;
  logic [7:0]  reg_rdata;
  logic [15:0] rx_l, tx_l, jp, jn, pmax, nmax;
  logic        own_l, cdr_c, cdr_d, los_d, jv, cdr_in, ext_m, mon_a, rclk_o, rdat_o;
  logic        los_o, tx_d, tx_lp, bw_o, run_o, int_n;
  logic [2:0]  term;
  logic [7:0]  exp_q[$];
  logic        rd_pend   = 1'b0;
  logic        int_prev  = 1'b1;
  int          err_count = 0;
  int          tests_run = 0;
  int          gap       = 0;
  int          cnt       = 0;
  int          seed;
  logic [5:0]  codes[7]  = '{6'h00, 6'h01, 6'h10, 6'h11, 6'h20, 6'h21, 6'h3f};

  always #25 mclk = ~mclk;

  mcj_monitor #(.PERIOD_COUNT(P)) i_dut (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .rx_line_data(rx_l), .tx_line_data(tx_l), .spare_line_data(own_l),
    .spare_cdr_clock(cdr_c), .spare_cdr_data(cdr_d), .spare_los_detect(los_d),
    .jitter_valid(jv), .jitter_pos(jp), .jitter_neg(jn), .spare_cdr_input(cdr_in),
    .spare_external_match(ext_m), .spare_termination(term), .spare_monitor_active(mon_a),
    .spare_receive_clock_out(rclk_o), .spare_receive_data_out(rdat_o), .spare_los(los_o),
    .spare_transmit_data(tx_d), .spare_transmit_loop(tx_lp),
    .jitter_bandwidth_select(bw_o), .jitter_meter_running(run_o), .int_n(int_n));

  mcj_far_end i_far (
    .mclk(mclk), .rx_line_data(rx_l), .tx_line_data(tx_l), .spare_line_data(own_l),
    .spare_cdr_clock(cdr_c), .spare_cdr_data(cdr_d), .spare_los_detect(los_d),
    .jitter_valid(jv), .jitter_pos(jp), .jitter_neg(jn));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("Checks run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe; gap counts edges between falls
  always @(posedge mclk) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) chk(16'(reg_rdata), 16'h0100);
      else chk(16'(reg_rdata), 16'(exp_q.pop_front()));
    end
    rd_pend  <= reg_read;
    int_prev <= int_n;
    if (int_prev === 1'b1 && int_n === 1'b0) begin
      gap <= cnt;
      cnt <= 1;
    end else begin
      cnt <= cnt + 1;
    end
  end

  task automatic wait_int(input int lim);
    for (int i = 0; i < lim && int_n !== 1'b0; i++) @(posedge mclk);
    if (int_n !== 1'b0) begin
      err_count++;
      stop_test();
    end
  endtask

  task automatic route(input logic [5:0] c, input logic [7:0] ctl);
    logic e, d, l, t, ck;
    logic on;
    on = (c >= 6'd1 && c <= 6'd32);
    wr(ADDR_CHANNEL_CONTROL, ctl);
    wr(ADDR_MONITOR_SELECT, {2'b00, c});
    repeat (2) @(posedge mclk);
    // Path value two cycles back is what the loop sends out now
    repeat (2) begin
      @(negedge mclk);
      t = e;
      e = (c >= 6'd1 && c <= 6'd16) ? rx_l[c - 6'd1] : on ? tx_l[c - 6'd17] : own_l;
    end
    d = cdr_d;
    l = los_d;
    ck = cdr_c;
    @(negedge mclk);
    chk(16'(cdr_in), 16'(e));
    chk(16'(mon_a), 16'(on));
    chk(16'(ext_m), 16'(on));
    chk(16'(term), on ? 16'h0000 : 16'(ctl[4:2]));
    chk(16'(rdat_o), 16'(d));
    chk(16'(rclk_o), 16'(ck));
    chk(16'(los_o), 16'(l));
    chk(16'(tx_lp), 16'(ctl[1]));
    chk(16'(tx_d), ctl[1] ? 16'(t) : 16'h0000);
  endtask

  // Random samples; the expected peak is the largest of each polarity
  task automatic round(input int n);
    logic [15:0] p, q;
    pmax = '0;
    nmax = '0;
    repeat (n) begin
      p = 16'($urandom);
      q = 16'($urandom);
      if (p > pmax) pmax = p;
      if (q > nmax) nmax = q;
      i_far.send(p, q);
    end
  endtask

  task automatic peaks();
    rd(ADDR_POS_PEAK_HIGH, pmax[15:8]);
    rd(ADDR_POS_PEAK_LOW, pmax[7:0]);
    rd(ADDR_NEG_PEAK_HIGH, nmax[15:8]);
    rd(ADDR_NEG_PEAK_LOW, nmax[7:0]);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    seed = $urandom(32'ha6b8b793);
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) rd(4'(a), 8'h00);
    foreach (codes[k]) route(codes[k], k[0] ? 8'h16 : 8'h14);
    // Manual rounds; a sample with the attenuator off must not count
    wr(ADDR_CHANNEL_CONTROL, 8'h00);
    i_far.send(16'hffff, 16'hffff);
    wr(ADDR_CHANNEL_CONTROL, 8'h01);
    round(6);
    wr(ADDR_JITTER_CONTROL, 8'h05);
    repeat (3) @(posedge mclk);
    chk(16'(bw_o), 16'h0001);
    peaks();
    wr(ADDR_JITTER_CONTROL, 8'h00);
    round(3);
    wr(ADDR_JITTER_CONTROL, 8'h04);
    repeat (3) @(posedge mclk);
    peaks();
    // Automatic period: flag, write-one clear, exact spacing of expiries
    wr(ADDR_JITTER_CONTROL, 8'h02);
    wr(ADDR_TIMER_STATUS, 8'h01);
    wait_int(2 * P + 20);
    wr(ADDR_TIMER_STATUS, 8'h00);
    rd(ADDR_TIMER_STATUS, 8'h01);
    wr(ADDR_TIMER_STATUS, 8'h01);
    rd(ADDR_TIMER_STATUS, 8'h00);
    chk(16'(int_n), 16'h0001);
    round(4);
    wait_int(2 * P);
    peaks();
    chk(16'(gap), 16'(P));
    // Masked expiry still sets the flag but keeps the line quiet
    wr(ADDR_GLOBAL_CONFIG, 8'h01);
    wr(ADDR_TIMER_STATUS, 8'h01);
    repeat (P + 10) @(posedge mclk);
    chk(16'(int_n), 16'h0001);
    rd(ADDR_TIMER_STATUS, 8'h01);
    repeat (2) @(posedge mclk);
    stop_test();
  end
endmodule

bind mcj_monitor mcj_monitor_chk #(.NUM_CH(NUM_CH), .PERIOD_COUNT(PERIOD_COUNT)) u_chk (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .spare_cdr_data(spare_cdr_data),
  .spare_los_detect(spare_los_detect), .spare_cdr_input(spare_cdr_input),
  .spare_external_match(spare_external_match), .spare_termination(spare_termination),
  .spare_monitor_active(spare_monitor_active),
  .spare_receive_data_out(spare_receive_data_out), .spare_los(spare_los),
  .spare_transmit_data(spare_transmit_data), .spare_transmit_loop(spare_transmit_loop),
  .jitter_bandwidth_select(jitter_bandwidth_select),
  .jitter_meter_running(jitter_meter_running), .int_n(int_n));
